/* design/csx_pkg.sv */
// Constants and types for the call/skip/xor execution block.
// Assumes a 16-bit instruction word and one instruction cycle per clock enable.
//
// Function
// - A relative call is decoded from the top five bits 11011 and carries an 11-bit signed word offset.
// - A relative call pushes the program counter plus 2 onto the return stack before the counter changes.
// - A relative call loads the program counter with the counter plus 2 plus twice the signed offset.
// - A relative call is one word and two cycles, the second cycle being a no-operation.
// - The all-ones low byte software reset instruction clears the program counter, W, N and Z in one cycle; the return stack data and data address are not reset.
// - The register-test skip reads the addressed register, touches no flag, and on zero discards the prefetched word.
// - The register-test skip takes one cycle, two when it skips, three when the skipped word is a two-word one.
// - A bank bit of 0 selects the access bank and ignores the bank select register; 1 uses the bank select register.
// - The literal XOR (prefix 00001010) XORs the working register with the literal and updates only N and Z.
`default_nettype none

package csx_pkg;
  localparam int unsigned CSX_IW = 16;
  localparam int unsigned CSX_PCW = 21;
  localparam int unsigned CSX_DAW = 12;
  localparam logic [4:0] CSX_CALL_PFX = 5'h1b;
  localparam logic [6:0] CSX_TST_PFX = 7'h33;
  localparam logic [7:0] CSX_XOR_PFX = 8'h0a;
  localparam logic [15:0] CSX_RESET_OP = 16'h00ff;
  localparam logic [20:0] CSX_PC_STEP = 21'h000002;
  localparam logic [20:0] CSX_PC_RST = 21'h000000;
  localparam logic [7:0] CSX_W_RST = 8'h00;
  localparam logic [3:0] CSX_BANK_RST = 4'h0;
  localparam logic [3:0] CSX_ACC_HI_BANK = 4'hf;
  localparam logic [7:0] CSX_ACC_SPLIT = 8'h80;
  // Top bits of two-word opcodes: move-file (4 bits), call (7 bits), goto and lfsr (8 bits)
  localparam logic [3:0] CSX_2W_MOVFF = 4'hc;
  localparam logic [6:0] CSX_2W_CALL = 7'h76;
  localparam logic [7:0] CSX_2W_GOTO = 8'hef;
  localparam logic [7:0] CSX_2W_LFSR = 8'hee;
  typedef enum logic [1:0] {CSX_RUN, CSX_FLUSH1, CSX_FLUSH2} csx_state_t;
endpackage : csx_pkg

`default_nettype wire

/* design/csx_bank_addr.sv */
// Data address former for file-register instructions.
// Assumes bank select value is stable during the decode cycle.
`default_nettype none

module csx_bank_addr (
  // Instruction fields
  input wire logic i_bank_bit,
  input wire logic [7:0] i_file,
  // Bank select register value
  input wire logic [3:0] i_bank,
  // Formed data address
  output logic [11:0] o_addr
);
  import csx_pkg::*;
  // Access bank: low half to bank 0, high half to the special bank
  always_comb begin
    if (i_bank_bit) begin
      o_addr = {i_bank, i_file};
    end else if (i_file < CSX_ACC_SPLIT) begin
      o_addr = {4'h0, i_file};
    end else begin
      o_addr = {CSX_ACC_HI_BANK, i_file};
    end
  end
endmodule : csx_bank_addr

`default_nettype wire

/* design/csx_exec.sv */
// Execution unit for relative call, software reset, register-test skip and literal XOR.
// Assumes i_ce marks one instruction cycle and i_instr holds the word in decode that cycle;
// the register file answers i_rd_data for that word in the same cycle; o_rd_addr shows its address one cycle later.
`default_nettype none

module csx_exec (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Fetch side
  input wire logic [csx_pkg::CSX_IW-1:0] i_instr,
  input wire logic i_instr_valid,
  // Register file side
  input wire logic [7:0] i_rd_data,
  input wire logic [3:0] i_bank_select_register,
  // Program counter and stack
  output logic [csx_pkg::CSX_PCW-1:0] o_program_counter,
  output logic [csx_pkg::CSX_PCW-1:0] o_push_data,
  output logic o_push,
  // Working register and flags
  output logic [7:0] o_w,
  output logic o_flag_n,
  output logic o_flag_z,
  // Data address and pipeline control
  output logic [csx_pkg::CSX_DAW-1:0] o_rd_addr,
  output logic o_flush,
  output logic o_soft_reset
);
  import csx_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [20:0] pc_ff, nxt_pc;
  logic [20:0] push_ff, nxt_push;
  logic push_v_ff, nxt_push_v;
  logic bub_ff, nxt_bub;
  logic [7:0] w_ff, nxt_w;
  logic n_ff, nxt_n, z_ff, nxt_z;
  logic flush_ff, nxt_flush, srst_ff, nxt_srst;
  logic [11:0] addr_ff, nxt_addr;
  logic [11:0] addr_c;
  csx_state_t state_ff, nxt_state;
  logic is_call, is_tst, is_xor, is_rst, is_2w;
  logic [20:0] off2;
  logic [7:0] xr;
  logic run_take, do_rst, do_call, do_skip, do_xor;

  assign is_call = i_instr[15:11] == CSX_CALL_PFX;
  assign is_tst = i_instr[15:9] == CSX_TST_PFX;
  assign is_xor = i_instr[15:8] == CSX_XOR_PFX;
  assign is_rst = i_instr == CSX_RESET_OP;
  // Word following a skipping test that needs its second word flushed too
  assign is_2w = (i_instr[15:12] == CSX_2W_MOVFF) || (i_instr[15:9] == CSX_2W_CALL) ||
                 (i_instr[15:8] == CSX_2W_GOTO) || (i_instr[15:8] == CSX_2W_LFSR);
  // Sign-extended offset doubled to a byte step
  assign off2 = {{9{i_instr[10]}}, i_instr[10:0], 1'b0};
  assign xr = w_ff ^ i_instr[7:0];

  csx_bank_addr u_bank (
    .i_bank_bit(i_instr[8]),
    .i_file(i_instr[7:0]),
    .i_bank(i_bank_select_register),
    .o_addr(addr_c)
  );

  // ----------------------------------------------------------------
  // Taken-word strobes
  // ----------------------------------------------------------------
  // A word runs only in RUN, on an enable pulse, when marked valid
  assign run_take = i_ce && i_instr_valid && (state_ff == CSX_RUN);
  assign do_rst = run_take && is_rst;
  assign do_call = run_take && is_call;
  assign do_skip = run_take && is_tst && (i_rd_data == 8'h00);
  assign do_xor = run_take && is_xor;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Bubble flag tells a call's dead cycle from a skipped second word
  always_comb begin
    nxt_state = state_ff;
    nxt_bub = bub_ff;
    if (i_ce) begin
      case (state_ff)
        CSX_RUN: begin
          if (do_call) begin
            nxt_state = CSX_FLUSH2;
            nxt_bub = 1'b1;
          end else if (do_skip) begin
            nxt_state = CSX_FLUSH1;
          end
        end
        CSX_FLUSH1: begin
          // A discarded two-word opcode drags its second word along
          if (is_2w) begin
            nxt_state = CSX_FLUSH2;
          end else begin
            nxt_state = CSX_RUN;
          end
        end
        CSX_FLUSH2: begin
          // Call bubble or second word, a no-operation either way
          nxt_state = CSX_RUN;
          nxt_bub = 1'b0;
        end
        default: begin
          nxt_state = CSX_RUN;
          nxt_bub = 1'b0;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff <= CSX_RUN;
      bub_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bub_ff <= nxt_bub;
    end
  end

  // ----------------------------------------------------------------
  // Program counter and return stack
  // ----------------------------------------------------------------
  // Counter moves 2 per word; the call bubble holds it, as the call already moved it
  always_comb begin
    nxt_pc = pc_ff;
    nxt_push = push_ff;
    nxt_push_v = 1'b0;
    if (do_rst) begin
      nxt_pc = CSX_PC_RST;
    end else if (do_call) begin
      nxt_push = pc_ff + CSX_PC_STEP;
      nxt_push_v = 1'b1;
      nxt_pc = pc_ff + CSX_PC_STEP + off2;
    end else if (run_take) begin
      nxt_pc = pc_ff + CSX_PC_STEP;
    end else if (i_ce && (state_ff == CSX_FLUSH1)) begin
      nxt_pc = pc_ff + CSX_PC_STEP;
    end else if (i_ce && (state_ff == CSX_FLUSH2) && !bub_ff) begin
      nxt_pc = pc_ff + CSX_PC_STEP;
    end
  end

  // Push pulse lasts one clock since it is set only on a taken call
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pc_ff <= CSX_PC_RST;
      push_ff <= CSX_PC_RST;
      push_v_ff <= 1'b0;
    end else begin
      pc_ff <= nxt_pc;
      push_ff <= nxt_push;
      push_v_ff <= nxt_push_v;
    end
  end

  // ----------------------------------------------------------------
  // Working register and flags
  // ----------------------------------------------------------------
  // Only the literal XOR and the software reset touch W, N and Z
  always_comb begin
    nxt_w = w_ff;
    nxt_n = n_ff;
    nxt_z = z_ff;
    if (do_rst) begin
      nxt_w = CSX_W_RST;
      nxt_n = 1'b0;
      nxt_z = 1'b0;
    end else if (do_xor) begin
      nxt_w = xr;
      nxt_n = xr[7];
      nxt_z = (xr == 8'h00);
    end
  end

  // Working register and flag registers
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      w_ff <= CSX_W_RST;
      n_ff <= 1'b0;
      z_ff <= 1'b0;
    end else begin
      w_ff <= nxt_w;
      n_ff <= nxt_n;
      z_ff <= nxt_z;
    end
  end

  // ----------------------------------------------------------------
  // Pipeline pulses and data address
  // ----------------------------------------------------------------
  // Flush drops the prefetched word; the reset pulse tells the rest of the core
  always_comb begin
    nxt_flush = 1'b0;
    nxt_srst = do_rst;
    nxt_addr = addr_c;
    if (do_call || do_skip) begin
      nxt_flush = 1'b1;
    end else if (i_ce && (state_ff == CSX_FLUSH1) && is_2w) begin
      nxt_flush = 1'b1;
    end
  end

  // Pulse and address registers
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      flush_ff <= 1'b0;
      srst_ff <= 1'b0;
      addr_ff <= 12'h000;
    end else begin
      flush_ff <= nxt_flush;
      srst_ff <= nxt_srst;
      addr_ff <= nxt_addr;
    end
  end

  // Outputs straight from flip-flops
  assign o_program_counter = pc_ff;
  assign o_push_data = push_ff;
  assign o_push = push_v_ff;
  assign o_w = w_ff;
  assign o_flag_n = n_ff;
  assign o_flag_z = z_ff;
  assign o_rd_addr = addr_ff;
  assign o_flush = flush_ff;
  assign o_soft_reset = srst_ff;
endmodule : csx_exec

`default_nettype wire

/* bench/csx_exec_props.sv */
// Checker for csx_exec: call, reset, skip and xor paths at the ports.
// Assumes the bench never sends a register-test skip into a flushed slot.
`default_nettype none
module csx_exec_props (
  // Clock, reset and fetch side
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_instr_valid,
  input wire logic [csx_pkg::CSX_IW-1:0] i_instr,
  input wire logic [7:0] i_rd_data,
  input wire logic [3:0] i_bank_select_register,
  // Watched outputs
  input wire logic [csx_pkg::CSX_PCW-1:0] o_program_counter,
  input wire logic [csx_pkg::CSX_PCW-1:0] o_push_data,
  input wire logic o_push,
  input wire logic [7:0] o_w,
  input wire logic o_flag_n,
  input wire logic o_flag_z,
  input wire logic [csx_pkg::CSX_DAW-1:0] o_rd_addr,
  input wire logic o_flush,
  input wire logic o_soft_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  import csx_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  // ----------
  // Properties
  // ----------
  call_decode_a: assert property (o_push |-> $past(i_ce && i_instr[15:11] == CSX_CALL_PFX))
    else $error("push without call");
  ret_addr_a: assert property (o_push |-> o_push_data == $past(o_program_counter) + CSX_PC_STEP)
    else $error("bad return address");
  call_target_a: assert property (o_push |->
    o_program_counter == o_push_data + {{9{$past(i_instr[10])}}, $past(i_instr[10:0]), 1'b0})
    else $error("bad call target");
  call_bubble_a: assert property (o_push |-> o_flush ##1 !o_push) else $error("call bubble wrong");
  soft_clear_a: assert property (o_soft_reset |-> $past(i_ce && i_instr == CSX_RESET_OP) &&
    o_program_counter == CSX_PC_RST && o_w == CSX_W_RST && !o_flag_n && !o_flag_z)
    else $error("soft reset wrong");
  xor_flags_a: assert property ($changed(o_w) && !o_soft_reset |->
    $past(i_ce && i_instr_valid && i_instr[15:8] == CSX_XOR_PFX) && o_flag_n == o_w[7] && o_flag_z == (o_w == 8'h00))
    else $error("w or flags wrong");
  skip_flush_a: assert property (i_ce && i_instr_valid && i_instr[15:9] == CSX_TST_PFX |=>
    o_flush == ($past(i_rd_data) == 8'h00) && $stable(o_flag_n) && $stable(o_flag_z))
    else $error("skip flush wrong");
  bank_addr_a: assert property ($past(i_ce && i_instr_valid && i_instr[15:9] == CSX_TST_PFX) |->
    o_rd_addr == {$past(i_instr[8]) ? $past(i_bank_select_register) :
    ($past(i_instr[7]) ? CSX_ACC_HI_BANK : CSX_BANK_RST), $past(i_instr[7:0])})
    else $error("data address wrong");
endmodule : csx_exec_props
bind csx_exec csx_exec_props u_props (.i_mclk, .i_rstn, .i_ce, .i_instr_valid, .i_instr, .i_rd_data,
  .i_bank_select_register, .o_program_counter, .o_push_data, .o_push, .o_w, .o_flag_n, .o_flag_z,
  .o_rd_addr, .o_flush, .o_soft_reset);
`default_nettype wire

/* bench/csx_exec_tb.sv */
// Bench for csx_exec: issues decode words and checks the results.
// Assumes one enable pulse per word with a quiet cycle between words.
`default_nettype none
module csx_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 1'b0, i_rstn = 1'b0, i_ce = 1'b0, i_instr_valid = 1'b0;
  logic [15:0] i_instr = 16'h0000;
  logic [7:0] i_rd_data = 8'h00, o_w, w_exp;
  logic [3:0] i_bank_select_register = 4'h3;
  logic [20:0] o_program_counter, o_push_data, pc;
  logic [11:0] o_rd_addr;
  logic o_push, o_flag_n, o_flag_z, o_flush, o_soft_reset;
  int fails = 0, n_tests = 0;
  csx_exec u_dut (.i_mclk, .i_rstn, .i_ce, .i_instr, .i_instr_valid, .i_rd_data, .i_bank_select_register,
    .o_program_counter, .o_push_data, .o_push, .o_w, .o_flag_n, .o_flag_z, .o_rd_addr, .o_flush, .o_soft_reset);
  // 50 MHz clock
  initial begin
    forever #10 i_mclk = ~i_mclk;
  end
  // ---------------
  // Shared tasks
  // ---------------
  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One word per enable pulse; the expected counter moves 2 per taken word
  task automatic go(input logic [15:0] w, input logic [7:0] rd, input logic v);
    @(posedge i_mclk);
    i_instr <= w;
    i_rd_data <= rd;
    i_instr_valid <= v;
    i_ce <= 1'b1;
    @(posedge i_mclk);
    i_ce <= 1'b0;
    #1;
    if (v) pc = pc + 21'h2;
  endtask : go
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // ---------------
  // Scenarios
  // ---------------
  task automatic t_xor;
    for (int i = 0; i < 3; i++) begin
      w_exp = w_exp ^ ((i == 0) ? 8'hb5 : (i == 1) ? 8'haf : 8'h1a);
      go({8'h0a, (i == 0) ? 8'hb5 : (i == 1) ? 8'haf : 8'h1a}, 8'h00, 1'b1);
      chk(o_w, w_exp);
      chk({o_flag_n, o_flag_z}, {w_exp[7], w_exp == 8'h00});
    end
    go(16'h0a55, 8'h00, 1'b0);
    chk(o_w, w_exp);
    $display("xor test done");
  endtask : t_xor
  task automatic t_call;
    go(16'hdc00, 8'h00, 1'b1);
    chk(o_push, 1'b1);
    chk(o_push_data, pc);
    pc = pc - 21'h000800;
    chk(o_program_counter, pc);
    go(16'h0aff, 8'h00, 1'b1);
    pc = pc - 21'h2;
    chk(o_program_counter, pc);
    chk(o_w, w_exp);
    go(16'hdbff, 8'h00, 1'b1);
    pc = pc + 21'h0007fe;
    chk(o_program_counter, pc);
    go(16'h0aff, 8'h00, 1'b1);
    pc = pc - 21'h2;
    go(16'hd3ff, 8'h00, 1'b1);
    chk(o_push, 1'b0);
    $display("call test done");
  endtask : t_call
  task automatic t_skip;
    go(16'h6685, 8'h00, 1'b1);
    chk({o_flush, o_rd_addr}, {1'b1, 12'hf85});
    go(16'h0aff, 8'h00, 1'b1);
    chk(o_w, w_exp);
    go(16'h6712, 8'h00, 1'b1);
    chk(o_rd_addr, 12'h312);
    go(16'hef00, 8'h00, 1'b1);
    chk(o_flush, 1'b1);
    go(16'h0a0f, 8'h00, 1'b1);
    chk(o_w, w_exp);
    chk(o_program_counter, pc);
    go(16'h6612, 8'h40, 1'b1);
    chk({o_flush, o_rd_addr}, {1'b0, 12'h012});
    go(16'h0a0f, 8'h00, 1'b1);
    w_exp = w_exp ^ 8'h0f;
    chk(o_w, w_exp);
    chk(o_program_counter, pc);
    $display("skip test done");
  endtask : t_skip
  task automatic t_soft;
    go(16'h00ff, 8'h00, 1'b1);
    chk({o_soft_reset, o_w, o_flag_n, o_flag_z}, 11'h400);
    chk(o_program_counter, 21'h0);
    $display("soft reset test done");
  endtask : t_soft
  // Main sequence
  initial begin
    w_exp = 8'h00;
    pc = 21'h0;
    repeat (16) @(posedge i_mclk);
    i_rstn <= 1'b1;
    t_xor();
    t_call();
    t_skip();
    t_soft();
    print_verdict();
  end
endmodule : csx_exec_tb
`default_nettype wire
